// File: verilog/sub_acc_pkg.sv
package sub_acc_pkg;
    // ----------------------------------------
    // Instruction word layout
    // ----------------------------------------
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int NIBBLE_W = 4; // Digit carry comes out of this many low bits
    localparam logic [5:0] SUBTRACT_ACC_FROM_FILE_OP = 6'h02;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] WDATA_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic STROBE_RESET = 1'b0;
endpackage

// File: verilog/subtract_accumulator_from_file.sv
`timescale 1ns/1ps
module subtract_accumulator_from_file (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Instruction from decoder
    input wire logic insn_valid_in,
    input wire logic [13:0] insn_in,
    // File register read data for the addressed register
    input wire logic [7:0] file_rdata_in,
    // File register write port
    output logic [6:0] file_addr_out,
    output logic file_we_out,
    output logic [7:0] file_wdata_out,
    // Accumulator and flags
    output logic [7:0] acc_out,
    output logic carry_flag_out,
    output logic digit_carry_flag_out,
    output logic zero_flag_out
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Opcode test on a whole word; the decode and the checks share it
    function automatic logic opcode_match(input logic [sub_acc_pkg::INSN_W-1:0] word);
        opcode_match = (word[sub_acc_pkg::OPC_MSB:sub_acc_pkg::OPC_LSB]
            == sub_acc_pkg::SUBTRACT_ACC_FROM_FILE_OP);
    endfunction

    // Destination field of a whole word; one means the file register
    function automatic logic dest_is_file(input logic [sub_acc_pkg::INSN_W-1:0] word);
        dest_is_file = word[sub_acc_pkg::DEST_BIT];
    endfunction

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    // Only a valid word with the subtract opcode is taken; all else is ignored
    wire logic is_sub = insn_valid_in && opcode_match(insn_in);
    wire logic dest_file = dest_is_file(insn_in);
    // Strobe and load selects, decoded once and shared by the registers
    wire logic next_file_we = is_sub && dest_file;
    wire logic acc_load = is_sub && !dest_file;

    // Address is combinational so the file can serve the operand this cycle
    assign file_addr_out = insn_in[sub_acc_pkg::ADDR_W-1:0];

    // ----------------------------------------
    // Borrow chain subtractor
    // ----------------------------------------
    // File minus accumulator; a plain ripple is short enough at eight bits
    // and gives the nibble borrow for free, so no second adder is needed
    wire logic [sub_acc_pkg::DATA_W:0] borrow;
    wire logic [sub_acc_pkg::DATA_W-1:0] diff;
    genvar bit_idx;

    // No borrow into the least significant stage
    assign borrow[0] = 1'b0;

    // One full subtractor per bit: difference and borrow out
    generate
        for (bit_idx = 0; bit_idx < sub_acc_pkg::DATA_W; bit_idx = bit_idx + 1) begin : g_stage
            wire logic minuend = file_rdata_in[bit_idx];
            wire logic subtrahend = acc_out[bit_idx];
            wire logic borrow_in = borrow[bit_idx];
            assign diff[bit_idx] = minuend ^ subtrahend ^ borrow_in;
            assign borrow[bit_idx + 1] = (~minuend & subtrahend)
                | (~(minuend ^ subtrahend) & borrow_in);
        end
    endgenerate

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    // Carry is the inverted final borrow: set unless the accumulator was larger
    wire logic next_carry = ~borrow[sub_acc_pkg::DATA_W];
    // Digit carry is the inverted borrow out of the low nibble
    wire logic next_digit_carry = ~borrow[sub_acc_pkg::NIBBLE_W];
    wire logic next_zero = (diff == 8'h00);
    // Accumulator only takes the result when the destination bit is clear
    wire logic [7:0] next_acc = acc_load ? diff : acc_out;

    // ----------------------------------------
    // Result registers
    // ----------------------------------------
    // Accumulator: every register commits on the edge that takes the word
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            acc_out <= sub_acc_pkg::ACC_RESET;
        end else begin
            acc_out <= next_acc;
        end
    end

    // File write strobe: one cycle per file-destination subtract
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            file_we_out <= sub_acc_pkg::STROBE_RESET;
        end else begin
            file_we_out <= next_file_we;
        end
    end

    // Write data also loads on accumulator results; harmless with the strobe low
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            file_wdata_out <= sub_acc_pkg::WDATA_RESET;
        end else if (is_sub) begin
            file_wdata_out <= diff;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Refreshed by every subtract whatever the destination; held otherwise
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            carry_flag_out <= sub_acc_pkg::FLAG_RESET;
            digit_carry_flag_out <= sub_acc_pkg::FLAG_RESET;
            zero_flag_out <= sub_acc_pkg::FLAG_RESET;
        end else if (is_sub) begin
            carry_flag_out <= next_carry;
            digit_carry_flag_out <= next_digit_carry;
            zero_flag_out <= next_zero;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // File destination: one strobe, carrying the difference
    file_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && dest_file
        |=> file_we_out && file_wdata_out == $past(file_rdata_in) - $past(acc_out))
        else $error("file write wrong");

    // Accumulator destination: no strobe, accumulator takes the difference
    acc_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && !dest_file
        |=> !file_we_out && acc_out == $past(file_rdata_in) - $past(acc_out))
        else $error("accumulator write wrong");

    // File destination leaves the accumulator alone
    acc_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && dest_is_file(insn_in)
        |=> $stable(acc_out))
        else $error("accumulator changed");

    // Positive difference: no borrow
    carry_pos_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && file_rdata_in > acc_out
        |=> carry_flag_out)
        else $error("carry not set on positive");

    // Equal operands: no borrow and a zero result
    carry_eq_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && file_rdata_in == acc_out
        |=> carry_flag_out && zero_flag_out)
        else $error("carry or zero wrong on equal");

    // Negative difference: borrow, and the wrapped result is never zero
    carry_neg_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && file_rdata_in < acc_out
        |=> !carry_flag_out && !zero_flag_out)
        else $error("carry set on negative");

    // Digit carry is the low nibble not-borrow
    digit_carry_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub
        |=> digit_carry_flag_out
            == ($past(file_rdata_in[sub_acc_pkg::NIBBLE_W-1:0])
            >= $past(acc_out[sub_acc_pkg::NIBBLE_W-1:0])))
        else $error("digit carry wrong");

    // Difference modulo 256, worked out without the chain
    diff_value_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub
        |=> file_wdata_out == 8'(9'h100 + $past(file_rdata_in) - $past(acc_out)))
        else $error("difference wrong");

    // No instruction: no strobe and carry held
    idle_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !is_sub
        |=> !file_we_out && $stable(carry_flag_out))
        else $error("state changed without instruction");

    // Zero flag follows equality of the operands
    zero_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub
        |=> zero_flag_out == ($past(file_rdata_in) == $past(acc_out)))
        else $error("zero flag wrong");

    // Other opcodes with valid high must not write anything
    other_opcode_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        insn_valid_in && !opcode_match(insn_in)
        |=> !file_we_out && $stable(acc_out))
        else $error("other opcode changed state");

    // No instruction: results and remaining flags held
    idle_state_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !is_sub
        |=> $stable(acc_out) && $stable(file_wdata_out)
            && $stable(digit_carry_flag_out) && $stable(zero_flag_out))
        else $error("results changed without instruction");

    // Three minus two: one, no borrow, not zero
    positive_example_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && file_rdata_in == 8'h03 && acc_out == 8'h02
        |=> file_wdata_out == 8'h01 && carry_flag_out && !zero_flag_out)
        else $error("three minus two wrong");

    // One minus two wraps to all ones with a borrow
    wrap_example_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && file_rdata_in == 8'h01 && acc_out == 8'h02
        |=> file_wdata_out == 8'hFF && !carry_flag_out)
        else $error("one minus two wrong");

    // Carry is refreshed for the accumulator destination as well
    flags_acc_dest_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_sub && !dest_file && file_rdata_in >= acc_out
        |=> carry_flag_out)
        else $error("carry not set on accumulator result");
endmodule

// File: tb/test_subtract_accumulator_from_file.sv
`timescale 1ns/1ps
module test_subtract_accumulator_from_file;
    // ----------------------------------------
    // Signals and expected state
    // ----------------------------------------
    localparam logic [5:0] OPC = sub_acc_pkg::SUBTRACT_ACC_FROM_FILE_OP;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic insn_valid_in = 1'b0;
    logic [13:0] insn_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [6:0] file_addr_out;
    logic file_we_out, carry_flag_out, digit_carry_flag_out, zero_flag_out;
    logic [7:0] file_wdata_out, acc_out;
    logic [7:0] acc = 8'h00, wd = 8'h00;
    logic [6:0] addr = 7'h00;
    logic c = 1'b0, dc = 1'b0, z = 1'b0, we = 1'b0;
    int miscompares = 0, total_checks = 0, seed = 32'h2724;
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    subtract_accumulator_from_file i_subtract_accumulator_from_file (.clk_in(clk_in),
        .rstn_in(rstn_in), .insn_valid_in(insn_valid_in), .insn_in(insn_in),
        .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out), .file_we_out(file_we_out),
        .file_wdata_out(file_wdata_out), .acc_out(acc_out), .carry_flag_out(carry_flag_out),
        .digit_carry_flag_out(digit_carry_flag_out), .zero_flag_out(zero_flag_out));
    // ----------------------------------------
    // Tasks: compare, one instruction, verdict
    // ----------------------------------------
    // Byte-wide results: data, accumulator, address
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    // Single-bit results: strobe and flags
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    // Expected {carry, digit carry, zero, difference} of file minus accumulator
    function automatic logic [10:0] expect_sub(input logic [7:0] f, input logic [7:0] a);
        logic [7:0] diff;
        diff = f - a;
        return {f >= a, f[3:0] >= a[3:0], diff == 8'h00, diff};
    endfunction
    // Expectation uses the old accumulator, so back to back chains are covered
    task automatic op(input logic v, input logic [5:0] opc, input logic d, input logic [7:0] f);
        addr = 7'($random(seed));
        insn_valid_in = v;
        insn_in = {opc, d, addr};
        file_rdata_in = f;
        we = v && opc == OPC && d;
        if (v && opc == OPC) begin
            {c, dc, z, wd} = expect_sub(f, acc);
            acc = d ? acc : wd;
        end
        @(posedge clk_in);
        #1;
        chk_byte({1'b0, file_addr_out}, {1'b0, addr});
        chk_byte(file_wdata_out, wd);
        chk_byte(acc_out, acc);
        chk_flag(file_we_out, we);
        chk_flag(carry_flag_out, c);
        chk_flag(digit_carry_flag_out, dc);
        chk_flag(zero_flag_out, z);
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Corner values first (3-2, 2-2, 1-2 with acc 2), then random mix
    initial begin
        repeat (16) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        op(1'b0, OPC, 1'b1, 8'h55);
        op(1'b1, OPC, 1'b0, 8'h02);
        op(1'b1, OPC, 1'b1, 8'h03);
        op(1'b1, OPC, 1'b1, 8'h02);
        op(1'b1, OPC, 1'b1, 8'h01);
        op(1'b1, 6'h0A, 1'b0, 8'h77);
        // Mid-run reset: model and design both fall back to reset values
        rstn_in = 1'b0;
        {acc, wd, c, dc, z, we} = '0;
        op(1'b0, OPC, 1'b0, 8'h11);
        rstn_in = 1'b1;
        op(1'b0, OPC, 1'b1, 8'h22);
        // Any other opcode may turn up; the model ignores it as the design must
        repeat (300) op(($random(seed) & 3) != 0,
            (($random(seed) & 7) == 0) ? 6'($random(seed)) : OPC,
            1'($random(seed)), 8'($random(seed)));
        summarize();
    end
endmodule
